// ==== common/flash_regs_defs.svh ====
// offsets, field positions, reset values and key words of the flash controller
`ifndef FLASH_REGS_DEFS_SVH
`define FLASH_REGS_DEFS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define OFS_UNLOCK_KEY  8'h04
`define OFS_OPTION_KEY  8'h08
`define OFS_STATUS      8'h0C
`define OFS_CONFIG      8'h10
`define OFS_OP_ADDR     8'h14
`define OFS_PAGE_DATA   8'h2C
`define OFS_FAST_KEY    8'h24
`define OFS_BOOT_KEY    8'h28

// ****************************************
// status fields
// ****************************************
`define ST_BOOT_LOCK    15
`define ST_BOOT_MODE    14
`define ST_DONE         5
`define ST_PROTECT      4
`define ST_PROG_ERR     2
`define ST_BUSY         0
`define STATUS_RESET    32'h0000_8000

// ****************************************
// configuration fields
// ****************************************
`define CF_BUF_CLEAR    19
`define CF_BUF_LOAD     18
`define CF_FAST_ERASE   17
`define CF_FAST_PROG    16
`define CF_FAST_LOCK    15
`define CF_DONE_IE      12
`define CF_ERR_IE       10
`define CF_OPT_WE       9
`define CF_CTRL_LOCK    7
`define CF_GO           6
`define CF_OPT_ERASE    5
`define CF_OPT_PROG     4
`define CF_MASS_ERASE   2
`define CF_SECT_ERASE   1
`define CF_STD_PROG     0
`define CONFIG_RESET    32'h0000_8080

// ****************************************
// unlock keys
// ****************************************
`define UNLOCK_KEY_FIRST  32'h4567_0123
`define UNLOCK_KEY_SECOND 32'hCDEF_89AB

`endif

// ==== common/flash_regs_pkg.sv ====
// types shared by the flash status and control logic
package flash_regs_pkg;

  // key sequence progress
  typedef enum logic [1:0] {KEY_IDLE, KEY_GOT_FIRST, KEY_FAILED} key_state_t;

  // operation launched by the go trigger
  typedef enum logic [2:0] {
    OP_NONE, OP_STD_PROG, OP_SECT_ERASE, OP_MASS_ERASE,
    OP_OPT_PROG, OP_OPT_ERASE, OP_FAST_PROG, OP_FAST_ERASE
  } op_kind_t;

  // request toward the flash array engine
  typedef struct packed {
    logic        start;
    op_kind_t    kind;
    logic [31:0] addr;
  } flash_req_t;

  // answer from the flash array engine
  typedef struct packed {
    logic done;
    logic protect_hit;
    logic prog_fail;
  } flash_rsp_t;

endpackage : flash_regs_pkg

// ==== dv/flash_regs_sva.sv ====
// assertion checker for the flash status and control registers
`timescale 1ns/1ps
module flash_regs_sva
  import flash_regs_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input logic                      core_clk,
  input logic                      rst_n,
  input logic [ADDR_W-1:0]         paddr,
  input logic                      psel,
  input logic                      penable,
  input logic                      pwrite,
  input logic [31:0]               pwdata,
  input flash_regs_pkg::flash_req_t flash_req,
  input flash_regs_pkg::flash_rsp_t flash_rsp,
  input logic                      irq,
  input logic                      boot_from_boot_area,
  input logic                      option_bytes_write_enable
);
  // ****
  // write decodes
  // ****
  wire wr = psel && penable && pwrite;  // apb write taken
  wire wcf = wr && paddr == 8'h10;      // configuration write
  wire wst = wr && paddr == 8'h0C;      // status write
  wire okey = wr && paddr == 8'h08 && pwdata == 32'hCDEF_89AB;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // launch is a single pulse
  sequence s_pulse;
    flash_req.start ##1 !flash_req.start;
  endsequence
  a_start_pulse: assert property ($rose(flash_req.start) |-> s_pulse)
    else $error("start pulse too long");
  a_start_cause: assert property (flash_req.start |-> $past(wcf && pwdata[6]))
    else $error("start without go write");
  a_kind_set: assert property (flash_req.start |-> flash_req.kind != OP_NONE)
    else $error("start with no operation");
  a_boot_cause: assert property ($changed(boot_from_boot_area) |-> $past(wst))
    else $error("boot area moved without write");
  a_opt_set: assert property ($rose(option_bytes_write_enable) |-> $past(okey) || $past(okey, 2))
    else $error("option enable without key");
  a_opt_clear: assert property ($fell(option_bytes_write_enable) |-> $past(wcf && !pwdata[9]))
    else $error("option enable dropped alone");
  a_irq_rise: assert property ($rose(irq) |-> $past(flash_rsp.done || wcf, 2))
    else $error("irq without cause");
  a_irq_fall: assert property ($fell(irq) |-> $past(wst || wcf, 2))
    else $error("irq dropped without clear");
endmodule : flash_regs_sva

bind flash_status_control_regs flash_regs_sva #(.ADDR_W(ADDR_W)) u_sva (
  .core_clk(core_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
  .flash_req(flash_req), .flash_rsp(flash_rsp), .irq(irq),
  .boot_from_boot_area(boot_from_boot_area),
  .option_bytes_write_enable(option_bytes_write_enable));

// ==== dv/test_flash_status_control_regs.sv ====
// self-checking bench for the flash status and control registers
`timescale 1ns/1ps
module test_flash_status_control_regs;
  import flash_regs_pkg::*;
  logic        core_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic        irq, boot, owe;
  logic [7:0]  paddr;
  logic [3:0]  buf_idx;
  logic [31:0] pwdata, prdata, rd_val, buf_data;
  flash_req_t  req;
  flash_rsp_t  rsp;
  int          n_mismatch, compares;

  flash_status_control_regs dut (.core_clk(core_clk), .rst_n(rst_n),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flash_req(req), .flash_rsp(rsp), .buf_rd_idx(buf_idx),
    .buf_rd_data(buf_data), .irq(irq), .boot_from_boot_area(boot),
    .option_bytes_write_enable(owe));

  // 100 mhz clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // ****
  // apb master: setup, access, wait bounded for pready
  // ****
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge core_clk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge core_clk);
      if (pready === 1'b1) break;
    end
    if (n == 16) begin
      n_mismatch++;
      tally_and_finish();
    end
    rd_val = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(a, 1'b0, 32'h0000_0000);
    chk(nm, e, rd_val);
  endtask : rd

  // both key words, then let the unlock land
  task automatic keys(input logic [7:0] a);
    wr(a, 32'h4567_0123);
    wr(a, 32'hCDEF_89AB);
    repeat (2) @(posedge core_clk);
  endtask : keys

  task automatic rs();
    rst_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
  endtask : rs

  // launch, check busy and go, end with a response, check flag and irq
  task automatic op(input logic [31:0] cfg, input op_kind_t k,
                    input flash_rsp_t r, input logic [31:0] fl);
    logic ei;
    ei = (fl == 32'h20) ? cfg[12] : cfg[10];
    wr(8'h10, cfg);
    wr(8'h10, cfg | 32'h40);
    @(posedge core_clk);
    chk("start", 1, req.start);
    chk("kind", k, req.kind);
    chk("addr", 32'h0800_0040, req.addr);
    rd(8'h0C, 32'h0000_8001, "busy");
    rd(8'h10, cfg | 32'h40, "go");
    rsp <= r;
    @(posedge core_clk);
    rsp <= 3'b000;
    repeat (2) @(posedge core_clk);
    chk("irq", ei, irq);
    rd(8'h0C, 32'h0000_8000 | fl, "flag");
    rd(8'h10, cfg, "go clear");
    wr(8'h0C, fl);
    repeat (2) @(posedge core_clk);
    chk("irq clear", 0, irq);
    rd(8'h0C, 32'h0000_8000, "flag clear");
  endtask : op

  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, buf_idx} = '0;
    rsp = 3'b000;
    rs();
    rd(8'h0C, 32'h0000_8000, "status reset");
    rd(8'h10, 32'h0000_8080, "config reset");
    rd(8'h30, 32'h0000_0000, "unmapped");
    chk("pslverr", 1, pslverr);
    $display("test reset done");
    keys(8'h04);
    rd(8'h10, 32'h0000_8000, "ctrl unlock");
    keys(8'h08);
    chk("opt enable", 1, owe);
    wr(8'h10, 32'h0002_0000);
    @(posedge core_clk);
    chk("opt relock", 0, owe);
    rd(8'h10, 32'h0000_8000, "fast locked");
    keys(8'h24);
    rd(8'h10, 32'h0000_0000, "fast unlock");
    wr(8'h2C, 32'hA5A5_0F0F);
    wr(8'h10, 32'h0004_0000);
    repeat (2) @(posedge core_clk);
    chk("buffer", 32'hA5A5_0F0F, buf_data);
    $display("test unlock done");
    wr(8'h14, 32'h0800_0040);
    op(32'h0002_1000, OP_FAST_ERASE, 3'b100, 32'h20);
    op(32'h0001_0000, OP_FAST_PROG, 3'b100, 32'h20);
    op(32'h0000_0401, OP_STD_PROG, 3'b110, 32'h10);
    op(32'h0000_0402, OP_SECT_ERASE, 3'b101, 32'h04);
    op(32'h0000_0004, OP_MASS_ERASE, 3'b100, 32'h20);
    op(32'h0000_1020, OP_OPT_ERASE, 3'b100, 32'h20);
    op(32'h0000_0410, OP_OPT_PROG, 3'b101, 32'h04);
    wr(8'h10, 32'h0000_8000);
    rd(8'h10, 32'h0000_8000, "fast relock");
    $display("test operations done");
    wr(8'h0C, 32'h0000_4000);
    rd(8'h0C, 32'h0000_8000, "boot locked");
    keys(8'h28);
    wr(8'h0C, 32'h0000_4000);
    rd(8'h0C, 32'h0000_4000, "boot mode");
    chk("boot out", 1, boot);
    wr(8'h0C, 32'h0000_C000);
    wr(8'h0C, 32'h0000_8000);
    rd(8'h0C, 32'h0000_C000, "boot relock");
    $display("test boot done");
    rs();
    wr(8'h04, 32'h1111_1111);
    keys(8'h04);
    rd(8'h10, 32'h0000_8080, "failed unlock");
    $display("test failed unlock done");
    tally_and_finish();
  end
endmodule : test_flash_status_control_regs

// ==== hdl/flash_status_control_regs.sv ====
// flash status and control registers on apb
//
// Contract
// - option key register is write-only, releases option write
// - boot lock high blocks boot mode writes
// - boot lock write one sets, resets to one
// - boot mode picks boot or user area
// - done flag set on success, write one clears
// - protect flag set on protected program, clears
// - busy bit read-only, high during operation
// - config bit 17 requests fast page erase
// - bits 16,18,19: fast program, load, buffer clear
// - fast lock blocks fast ops, write one only
// - correct sequence clears fast lock, one relocks
// - done enable gates done interrupt
// - error enable gates error interrupt
// - option sequence sets option write enable, zero clears
// - go starts operation, clears when busy drops
// - failed unlock keeps controller lock until reset
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`include "flash_regs_defs.svh"
module flash_status_control_regs #(
  parameter int ADDR_W = 8,
  parameter int PAGE_WORDS = 16
) (
  input  wire logic                          core_clk,
  input  wire logic                          rst_n,
  input  wire logic [ADDR_W-1:0]             paddr,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  output flash_regs_pkg::flash_req_t         flash_req,
  input  wire flash_regs_pkg::flash_rsp_t    flash_rsp,
  input  wire logic [$clog2(PAGE_WORDS)-1:0] buf_rd_idx,
  output logic      [31:0]                   buf_rd_data,
  output logic                               irq,
  output logic                               boot_from_boot_area,
  output logic                               option_bytes_write_enable
);
  import flash_regs_pkg::*;

  localparam int IDX_W = $clog2(PAGE_WORDS);

  // ****************************************
  // reset release
  // ****************************************
  logic [1:0] rst_pipe_reg;  // two-stage release of rst_n
  logic       rst_sync_n;    // synchronous-release reset

  // assert at once, release after two edges
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe_reg <= 2'b00;
    end else begin
      rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_pipe_reg[1];

  // ****************************************
  // apb decode
  // ****************************************
  // match one register offset
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0]        ofs);
    hit = (a == ADDR_W'(ofs));
  endfunction : hit

  wire wr_access  = psel & penable & pwrite;   // write takes effect
  wire setup      = psel & ~penable;           // setup cycle
  wire hit_ukey   = hit(paddr, `OFS_UNLOCK_KEY);
  wire hit_okey   = hit(paddr, `OFS_OPTION_KEY);
  wire hit_stat   = hit(paddr, `OFS_STATUS);
  wire hit_cfg    = hit(paddr, `OFS_CONFIG);
  wire hit_addr   = hit(paddr, `OFS_OP_ADDR);
  wire hit_data   = hit(paddr, `OFS_PAGE_DATA);
  wire hit_fkey   = hit(paddr, `OFS_FAST_KEY);
  wire hit_bkey   = hit(paddr, `OFS_BOOT_KEY);
  wire mapped     = hit_ukey | hit_okey | hit_stat | hit_cfg |
                    hit_addr | hit_data | hit_fkey | hit_bkey;
  wire wr_stat    = wr_access & hit_stat;
  wire wr_cfg     = wr_access & hit_cfg;

  // always ready: reads are prepared in the setup cycle
  assign pready = 1'b1;

  // ****************************************
  // key sequences
  // ****************************************
  logic ctrl_unlock;   // controller key accepted
  logic ctrl_failed;   // controller key rejected, sticky
  logic opt_unlock;    // option key accepted
  logic fast_unlock;   // fast mode key accepted
  logic boot_unlock;   // boot key accepted

  // controller key; a bad attempt sticks until reset
  key_sequencer #(.STICKY_FAIL(1'b1)) u_ctrl_key (
    .core_clk     (core_clk),
    .rst_sync_n   (rst_sync_n),
    .key_wr       (wr_access & hit_ukey),
    .key_data     (pwdata),
    .unlock_pulse (ctrl_unlock),
    .failed       (ctrl_failed)
  );

  // option key register is write-only and only feeds this
  key_sequencer #(.STICKY_FAIL(1'b0)) u_opt_key (
    .core_clk     (core_clk),
    .rst_sync_n   (rst_sync_n),
    .key_wr       (wr_access & hit_okey),
    .key_data     (pwdata),
    .unlock_pulse (opt_unlock),
    .failed       ()
  );

  // fast mode key
  key_sequencer #(.STICKY_FAIL(1'b0)) u_fast_key (
    .core_clk     (core_clk),
    .rst_sync_n   (rst_sync_n),
    .key_wr       (wr_access & hit_fkey),
    .key_data     (pwdata),
    .unlock_pulse (fast_unlock),
    .failed       ()
  );

  // boot lock key
  key_sequencer #(.STICKY_FAIL(1'b0)) u_boot_key (
    .core_clk     (core_clk),
    .rst_sync_n   (rst_sync_n),
    .key_wr       (wr_access & hit_bkey),
    .key_data     (pwdata),
    .unlock_pulse (boot_unlock),
    .failed       ()
  );

  // ****************************************
  // configuration register
  // ****************************************
  logic        ctrl_lock_reg;     // controller locked
  logic        fast_lock_reg;     // fast mode locked
  logic        opt_we_reg;        // option bytes writable
  logic        go_reg;            // operation launched
  logic        done_ie_reg;       // done interrupt enable
  logic        err_ie_reg;        // error interrupt enable
  logic [3:0]  fast_bits_reg;     // clear, load, erase, program
  logic [4:0]  std_bits_reg;      // opt erase, opt prog, mer, per, pg
  logic [31:0] op_addr_reg;       // target address
  logic [31:0] page_data_reg;     // word staged for buffer load
  logic        busy_reg;          // operation in flight

  wire cfg_open  = wr_cfg & ~ctrl_lock_reg;   // config accepts writes
  wire fast_open = cfg_open & ~fast_lock_reg; // fast bits writable
  // go only launches when idle and something is selected
  wire launch = cfg_open & pwdata[`CF_GO] & ~busy_reg & ~go_reg &
                ((|std_bits_reg) | (|fast_bits_reg[1:0]));
  wire buf_load  = fast_open & pwdata[`CF_BUF_LOAD];
  wire buf_clear = fast_open & pwdata[`CF_BUF_CLEAR];

  // controller lock: clear on good key, never after a failure
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ctrl_lock_reg <= 1'b1;
    end else if (ctrl_unlock && !ctrl_failed) begin
      ctrl_lock_reg <= 1'b0;
    end else if (wr_cfg && pwdata[`CF_CTRL_LOCK]) begin
      ctrl_lock_reg <= 1'b1;
    end
  end

  // fast lock: cleared by its key, write one relocks
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      fast_lock_reg <= 1'b1;
    end else if (cfg_open && pwdata[`CF_FAST_LOCK]) begin
      fast_lock_reg <= 1'b1;
    end else if (fast_unlock && !ctrl_lock_reg) begin
      fast_lock_reg <= 1'b0;
    end
  end

  // option write enable: set by its key, software zero clears
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      opt_we_reg <= 1'b0;
    end else if (opt_unlock && !ctrl_lock_reg) begin
      opt_we_reg <= 1'b1;
    end else if (cfg_open && !pwdata[`CF_OPT_WE]) begin
      opt_we_reg <= 1'b0;
    end
  end

  // plain writable control fields
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      done_ie_reg   <= 1'b0;
      err_ie_reg    <= 1'b0;
      std_bits_reg  <= 5'b0_0000;
      fast_bits_reg <= 4'b0000;
    end else begin
      if (cfg_open) begin
        done_ie_reg  <= pwdata[`CF_DONE_IE];
        err_ie_reg   <= pwdata[`CF_ERR_IE];
        std_bits_reg <= {pwdata[`CF_OPT_ERASE], pwdata[`CF_OPT_PROG],
                         pwdata[`CF_MASS_ERASE], pwdata[`CF_SECT_ERASE],
                         pwdata[`CF_STD_PROG]};
      end
      // fast fields ignored while fast mode is locked
      if (fast_open) begin
        fast_bits_reg <= {pwdata[`CF_BUF_CLEAR], pwdata[`CF_BUF_LOAD],
                          pwdata[`CF_FAST_ERASE],
                          pwdata[`CF_FAST_PROG]};
      end else if (fast_lock_reg) begin
        fast_bits_reg <= 4'b0000;
      end
    end
  end

  // go trigger: set on launch, drops once busy is clear
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      go_reg <= 1'b0;
    end else if (launch) begin
      go_reg <= 1'b1;
    end else if (!busy_reg) begin
      go_reg <= 1'b0;
    end
  end

  // address and staged data; address frozen while busy
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      op_addr_reg   <= 32'h0000_0000;
      page_data_reg <= 32'h0000_0000;
    end else begin
      if (wr_access && hit_addr && !busy_reg) begin
        op_addr_reg <= pwdata;
      end
      if (wr_access && hit_data) begin
        page_data_reg <= pwdata;
      end
    end
  end

  // ****************************************
  // page buffer
  // ****************************************
  logic [IDX_W-1:0] load_idx_reg;  // next word slot to fill

  // fill slots in order; clearing rewinds to the first
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      load_idx_reg <= '0;
    end else if (buf_clear) begin
      load_idx_reg <= '0;
    end else if (buf_load) begin
      load_idx_reg <= load_idx_reg + IDX_W'(1);
    end
  end

  page_buffer_mem #(.WORDS(PAGE_WORDS), .WIDTH(32)) u_page_buf (
    .core_clk (core_clk),
    .wr_en    (buf_load & ~buf_clear),
    .wr_idx   (load_idx_reg),
    .wr_data  (page_data_reg),
    .rd_idx   (buf_rd_idx),
    .rd_data  (buf_rd_data)
  );

  // ****************************************
  // operation select and request
  // ****************************************
  // fast erase wins, then fast program, then the standard set
  wire op_kind_t sel_kind =
      fast_bits_reg[1] ? OP_FAST_ERASE :
      fast_bits_reg[0] ? OP_FAST_PROG  :
      std_bits_reg[2]  ? OP_MASS_ERASE :
      std_bits_reg[1]  ? OP_SECT_ERASE :
      std_bits_reg[4]  ? OP_OPT_ERASE  :
      std_bits_reg[3]  ? OP_OPT_PROG   :
      std_bits_reg[0]  ? OP_STD_PROG   : OP_NONE;

  // one-cycle start with the selected kind and address
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      flash_req <= '0;
    end else begin
      flash_req.start <= launch;
      flash_req.kind  <= launch ? sel_kind : flash_req.kind;
      flash_req.addr  <= launch ? op_addr_reg : flash_req.addr;
    end
  end

  // ****************************************
  // status register
  // ****************************************
  logic boot_lock_reg;  // boot mode locked
  logic boot_mode_reg;  // boot area after soft reset
  logic done_reg;       // operation ended well
  logic prot_reg;       // protected address hit
  logic program_error_flag_reg;      // programming failed

  wire end_op   = busy_reg & flash_rsp.done;
  wire set_prot = end_op & flash_rsp.protect_hit;
  wire set_pge  = end_op & flash_rsp.prog_fail & ~flash_rsp.protect_hit;
  wire set_done = end_op & ~flash_rsp.protect_hit & ~flash_rsp.prog_fail;

  // busy rises with the request, falls with the result
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      busy_reg <= 1'b0;
    end else if (launch) begin
      busy_reg <= 1'b1;
    end else if (end_op) begin
      busy_reg <= 1'b0;
    end
  end

  // sticky flags; a set in the clearing cycle wins
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      done_reg  <= 1'b0;
      prot_reg  <= 1'b0;
      program_error_flag_reg <= 1'b0;
    end else begin
      done_reg  <= set_done |
                   (done_reg & ~(wr_stat & pwdata[`ST_DONE]));
      prot_reg  <= set_prot |
                   (prot_reg & ~(wr_stat & pwdata[`ST_PROTECT]));
      program_error_flag_reg <= set_pge |
                   (program_error_flag_reg & ~(wr_stat & pwdata[`ST_PROG_ERR]));
    end
  end

  // boot lock and boot area select
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      boot_lock_reg <= 1'b1;
      boot_mode_reg <= 1'b0;
    end else begin
      if (wr_stat && pwdata[`ST_BOOT_LOCK]) begin
        boot_lock_reg <= 1'b1;
      end else if (boot_unlock) begin
        boot_lock_reg <= 1'b0;
      end
      if (wr_stat && !boot_lock_reg) begin
        boot_mode_reg <= pwdata[`ST_BOOT_MODE];
      end
    end
  end

  // ****************************************
  // interrupt and side outputs
  // ****************************************
  // level request, held while any enabled flag stands
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      irq <= 1'b0;
    end else begin
      irq <= (done_reg & done_ie_reg) |
             ((prot_reg | program_error_flag_reg) & err_ie_reg);
    end
  end

  assign boot_from_boot_area       = boot_mode_reg;
  assign option_bytes_write_enable = opt_we_reg;

  // ****************************************
  // read data
  // ****************************************
  wire [31:0] status_word = {16'h0000, boot_lock_reg, boot_mode_reg,
                             8'h00, done_reg, prot_reg, 1'b0,
                             program_error_flag_reg, 1'b0, busy_reg};
  wire [31:0] config_word = {12'h000, fast_bits_reg, fast_lock_reg,
                             2'b00, done_ie_reg, 1'b0, err_ie_reg,
                             opt_we_reg, 1'b0, ctrl_lock_reg, go_reg,
                             std_bits_reg[4:3], 1'b0,
                             std_bits_reg[2:0]};
  // key, address and data registers read back as zero
  wire [31:0] rd_mux = hit_stat ? status_word :
                       hit_cfg  ? config_word : 32'h0000_0000;

  // captured in setup so the access phase answers at once
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr <= ~mapped;
    end
  end

endmodule : flash_status_control_regs

// ==== hdl/key_sequencer.sv ====
// two-word key sequence detector for one key register
`timescale 1ns/1ps
`include "flash_regs_defs.svh"
module key_sequencer #(
  parameter bit STICKY_FAIL = 1'b1
) (
  input  wire logic        core_clk,
  input  wire logic        rst_sync_n,
  input  wire logic        key_wr,
  input  wire logic [31:0] key_data,
  output logic             unlock_pulse,
  output logic             failed
);
  import flash_regs_pkg::*;

  // ****************************************
  // sequence state
  // ****************************************
  key_state_t state_reg;   // progress through the two words
  key_state_t state_next;  // next progress
  logic       unlock_next; // one-cycle success

  // step on each key write; a wrong word ends in failure when STICKY_FAIL is set, else returns to idle
  always_comb begin
    state_next  = state_reg;
    unlock_next = 1'b0;
    case (state_reg)
      KEY_IDLE: begin
        if (key_wr) begin
          state_next = (key_data == `UNLOCK_KEY_FIRST) ? KEY_GOT_FIRST
                     : (STICKY_FAIL ? KEY_FAILED : KEY_IDLE);
        end
      end
      KEY_GOT_FIRST: begin
        if (key_wr) begin
          unlock_next = (key_data == `UNLOCK_KEY_SECOND);
          state_next  = (unlock_next || !STICKY_FAIL) ? KEY_IDLE
                                                      : KEY_FAILED;
        end
      end
      // held until the next reset
      KEY_FAILED: state_next = KEY_FAILED;
      default:    state_next = KEY_IDLE;
    endcase
  end

  // state and pulse flops
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_reg    <= KEY_IDLE;
      unlock_pulse <= 1'b0;
    end else begin
      state_reg    <= state_next;
      unlock_pulse <= unlock_next;
    end
  end

  assign failed = (state_reg == KEY_FAILED);

endmodule : key_sequencer

// ==== hdl/page_buffer_mem.sv ====
// page buffer storage with registered read data
`timescale 1ns/1ps
module page_buffer_mem #(
  parameter int WORDS = 16,
  parameter int WIDTH = 32
) (
  input  wire logic                     core_clk,
  input  wire logic                     wr_en,
  input  wire logic [$clog2(WORDS)-1:0] wr_idx,
  input  wire logic [WIDTH-1:0]         wr_data,
  input  wire logic [$clog2(WORDS)-1:0] rd_idx,
  output logic      [WIDTH-1:0]         rd_data
);

  // ****************************************
  // storage
  // ****************************************
  logic [WIDTH-1:0] mem [WORDS];  // one page of words

  // write and registered read; no reset so it maps to ram
  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
    rd_data <= mem[rd_idx];
  end

endmodule : page_buffer_mem
